// ===== bsf_exec.sv
// Execution unit for flag branches, I/O bit ops, shifts and flag moves
`timescale 1ns/100ps
module bsf_exec (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // Instruction issue
    input wire logic in_valid,
    input wire bsf_pkg::bsf_instr_s in_instr,
    output logic issue_ready,
    // Completion and write-back
    output logic done,
    output bsf_pkg::bsf_wb_s wb,
    output logic [bsf_pkg::PC_W-1:0] pc,
    output logic [bsf_pkg::DATA_W-1:0] status_flags,
    // Register bus
    input wire logic [bsf_pkg::BUS_ADDR_W-1:0] bus_addr,
    input wire logic [bsf_pkg::DATA_W-1:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [bsf_pkg::DATA_W-1:0] bus_rdata
);

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_BRANCH,
        ST_IO_MOD
    } bsf_state_e;

    // Branch condition from the current flags
    function automatic logic branch_cond(input bsf_pkg::bsf_op_e op,
                                         input logic [bsf_pkg::DATA_W-1:0] f);
        logic nv;
        nv = f[bsf_pkg::FLAG_N] ^ f[bsf_pkg::FLAG_V];
        unique case (op)
            bsf_pkg::OP_BRANCH_ON_NEGATIVE: branch_cond = f[bsf_pkg::FLAG_N];
            bsf_pkg::OP_BRANCH_ON_POSITIVE: branch_cond = ~f[bsf_pkg::FLAG_N];
            bsf_pkg::OP_BRANCH_SIGNED_GE: branch_cond = ~nv;
            bsf_pkg::OP_BRANCH_SIGNED_LT: branch_cond = nv;
            bsf_pkg::OP_BRANCH_HALF_CARRY_ONE: branch_cond = f[bsf_pkg::FLAG_H];
            bsf_pkg::OP_BRANCH_HALF_CARRY_ZERO: branch_cond = ~f[bsf_pkg::FLAG_H];
            bsf_pkg::OP_BRANCH_XFER_FLAG_ONE: branch_cond = f[bsf_pkg::FLAG_T];
            bsf_pkg::OP_BRANCH_XFER_FLAG_ZERO: branch_cond = ~f[bsf_pkg::FLAG_T];
            bsf_pkg::OP_BRANCH_OVERFLOW_ONE: branch_cond = f[bsf_pkg::FLAG_V];
            bsf_pkg::OP_BRANCH_OVERFLOW_ZERO: branch_cond = ~f[bsf_pkg::FLAG_V];
            bsf_pkg::OP_BRANCH_IRQ_ON: branch_cond = f[bsf_pkg::FLAG_I];
            bsf_pkg::OP_BRANCH_IRQ_OFF: branch_cond = ~f[bsf_pkg::FLAG_I];
            default: branch_cond = 1'b0;
        endcase
    endfunction : branch_cond

    // True for every conditional branch opcode
    function automatic logic is_branch(input bsf_pkg::bsf_op_e op);
        is_branch = (op >= bsf_pkg::OP_BRANCH_ON_NEGATIVE) &&
                    (op <= bsf_pkg::OP_BRANCH_IRQ_OFF);
    endfunction : is_branch

    // Sequencing and completion
    bsf_state_e state_reg, state_next;
    logic ready_reg, ready_next;
    logic done_reg, done_next;

    // Write-back, pc and flags
    logic wb_valid_reg, wb_valid_next;
    logic [bsf_pkg::DATA_W-1:0] wb_data_reg, wb_data_next;
    logic [bsf_pkg::PC_W-1:0] pc_reg, pc_next;
    logic [bsf_pkg::DATA_W-1:0] flags_reg, flags_next;

    // I/O bit op in flight
    logic [bsf_pkg::IO_ADDR_W-1:0] io_addr_reg, io_addr_next;
    logic [bsf_pkg::BIT_SEL_W-1:0] io_bit_reg, io_bit_next;
    logic io_set_reg, io_set_next;

    // Bus read capture
    logic [bsf_pkg::DATA_W-1:0] local_rdata_reg, local_rdata_next;
    logic rd_io_reg, rd_io_next;

    logic take;
    logic [bsf_pkg::PC_W-1:0] pc_inc;
    logic [bsf_pkg::PC_W-1:0] offset_ext;
    logic [bsf_pkg::PC_W-1:0] pc_target;

    // Shift unit results
    logic [bsf_pkg::DATA_W-1:0] sh_result;
    logic sh_c;
    logic sh_z;
    logic sh_n;
    logic sh_v;

    // I/O memory ports
    logic mem_we;
    logic [bsf_pkg::IO_ADDR_W-1:0] mem_waddr;
    logic [bsf_pkg::DATA_W-1:0] mem_wdata;
    logic [bsf_pkg::DATA_W-1:0] mem_rda;
    logic [bsf_pkg::DATA_W-1:0] mem_rdb;
    logic [bsf_pkg::DATA_W-1:0] io_modified;
    logic bus_io_sel;

    // Offers made while busy are dropped, not queued
    assign take = in_valid && ready_reg;
    assign bus_io_sel = (bus_addr < bsf_pkg::ADDR_STATUS);
    assign pc_inc = pc_reg + bsf_pkg::PC_STEP;
    // Offset counts words; sign-extended to the pc width
    assign offset_ext = {{(bsf_pkg::PC_W - bsf_pkg::K_W){in_instr.offset[bsf_pkg::K_W-1]}},
                         in_instr.offset};
    // Target is one past the branch plus the offset
    assign pc_target = pc_inc + offset_ext;

    bsf_shift_unit u_shift (
        .op(in_instr.op),
        .operand(in_instr.operand),
        .bit_sel(in_instr.bit_sel),
        .carry_in(flags_reg[bsf_pkg::FLAG_C]),
        .xfer_in(flags_reg[bsf_pkg::FLAG_T]),
        .result(sh_result),
        .carry_out(sh_c),
        .zero_out(sh_z),
        .neg_out(sh_n),
        .ovf_out(sh_v)
    );

    bsf_io_mem u_io_mem (
        .ref_clk(ref_clk),
        .srst(srst),
        .wr_en(mem_we),
        .wr_addr(mem_waddr),
        .wr_data(mem_wdata),
        .rda_addr(io_addr_next),
        .rda_data(mem_rda),
        .rdb_addr(bus_addr[bsf_pkg::IO_ADDR_W-1:0]),
        .rdb_data(mem_rdb)
    );

    // Read-modify-write of the addressed I/O bit
    always_comb begin
        io_modified = mem_rda;
        io_modified[io_bit_reg] = io_set_reg;
    end

    // I/O write port: the bit op wins; a colliding bus write is dropped
    always_comb begin
        mem_we = 1'b0;
        mem_waddr = bus_addr[bsf_pkg::IO_ADDR_W-1:0];
        mem_wdata = bus_wdata;
        if (state_reg == ST_IO_MOD) begin
            mem_we = 1'b1;
            mem_waddr = io_addr_reg;
            mem_wdata = io_modified;
        end else if (bus_wr && bus_io_sel) begin
            mem_we = 1'b1;
        end
    end

    // Sequencing, PC, flags and write-back
    always_comb begin
        state_next = state_reg;
        ready_next = ready_reg;
        done_next = 1'b0;
        wb_valid_next = 1'b0;
        wb_data_next = wb_data_reg;
        pc_next = pc_reg;
        flags_next = flags_reg;
        io_addr_next = io_addr_reg;
        io_bit_next = io_bit_reg;
        io_set_next = io_set_reg;
        // Software write to the status register lands first
        if (bus_wr && bus_addr == bsf_pkg::ADDR_STATUS) begin
            flags_next = bus_wdata;
        end

        unique case (state_reg)
            ST_IDLE: begin
                if (take) begin
                    done_next = 1'b1;
                    pc_next = pc_inc;
                    if (is_branch(in_instr.op)) begin
                        // Not taken: one cycle; taken: second cycle follows
                        if (branch_cond(in_instr.op, flags_reg)) begin
                            pc_next = pc_target;
                            done_next = 1'b0;
                            ready_next = 1'b0;
                            state_next = ST_BRANCH;
                        end
                    end else begin
                        unique case (in_instr.op)
                            bsf_pkg::OP_IO_BIT_SET, bsf_pkg::OP_IO_BIT_CLEAR: begin
                                // Two cycles: read now, write back next
                                done_next = 1'b0;
                                ready_next = 1'b0;
                                pc_next = pc_reg;
                                io_addr_next = in_instr.io_addr;
                                io_bit_next = in_instr.bit_sel;
                                io_set_next = (in_instr.op == bsf_pkg::OP_IO_BIT_SET);
                                state_next = ST_IO_MOD;
                            end
                            bsf_pkg::OP_LOGICAL_LEFT_SHIFT, bsf_pkg::OP_LOGICAL_RIGHT_SHIFT,
                            bsf_pkg::OP_ROTATE_LEFT_CARRY, bsf_pkg::OP_ROTATE_RIGHT_CARRY: begin
                                wb_valid_next = 1'b1;
                                wb_data_next = sh_result;
                                flags_next[bsf_pkg::FLAG_C] = sh_c;
                                flags_next[bsf_pkg::FLAG_Z] = sh_z;
                                flags_next[bsf_pkg::FLAG_N] = sh_n;
                                flags_next[bsf_pkg::FLAG_V] = sh_v;
                            end
                            bsf_pkg::OP_XFER_FLAG_TO_BIT: begin
                                wb_valid_next = 1'b1;
                                wb_data_next = sh_result;
                            end
                            bsf_pkg::OP_BIT_TO_XFER_FLAG: begin
                                flags_next[bsf_pkg::FLAG_T] = in_instr.operand[in_instr.bit_sel];
                            end
                            bsf_pkg::OP_HALF_CARRY_SET: flags_next[bsf_pkg::FLAG_H] = 1'b1;
                            bsf_pkg::OP_HALF_CARRY_CLEAR: flags_next[bsf_pkg::FLAG_H] = 1'b0;
                            bsf_pkg::OP_OVERFLOW_FLAG_SET: flags_next[bsf_pkg::FLAG_V] = 1'b1;
                            bsf_pkg::OP_OVERFLOW_FLAG_CLEAR: flags_next[bsf_pkg::FLAG_V] = 1'b0;
                            bsf_pkg::OP_SIGNED_TEST_SET: flags_next[bsf_pkg::FLAG_S] = 1'b1;
                            bsf_pkg::OP_SIGNED_TEST_CLEAR: flags_next[bsf_pkg::FLAG_S] = 1'b0;
                            default: begin
                                pc_next = pc_inc;
                            end
                        endcase
                    end
                end
            end
            ST_BRANCH: begin
                // Second cycle of a taken branch; flags untouched
                done_next = 1'b1;
                ready_next = 1'b1;
                state_next = ST_IDLE;
            end
            ST_IO_MOD: begin
                done_next = 1'b1;
                ready_next = 1'b1;
                pc_next = pc_inc;
                state_next = ST_IDLE;
            end
            default: begin
                // Unused state code: recover to idle
                ready_next = 1'b1;
                state_next = ST_IDLE;
            end
        endcase
    end

    // Bus read capture; I/O space comes from the memory's own register
    always_comb begin
        local_rdata_next = local_rdata_reg;
        rd_io_next = rd_io_reg;
        if (bus_rd) begin
            rd_io_next = bus_io_sel;
            unique case (bus_addr)
                bsf_pkg::ADDR_STATUS: local_rdata_next = flags_reg;
                bsf_pkg::ADDR_PC_LO: local_rdata_next = pc_reg[bsf_pkg::DATA_W-1:0];
                bsf_pkg::ADDR_PC_HI: local_rdata_next = pc_reg[bsf_pkg::PC_W-1:bsf_pkg::DATA_W];
                default: local_rdata_next = bsf_pkg::DATA_ZERO;
            endcase
        end
    end

    // State registers
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state_reg <= ST_IDLE;
            ready_reg <= 1'b1;
            done_reg <= 1'b0;
            wb_valid_reg <= 1'b0;
            wb_data_reg <= bsf_pkg::DATA_ZERO;
            pc_reg <= bsf_pkg::PC_RST;
            flags_reg <= bsf_pkg::STATUS_RST;
            io_addr_reg <= '0;
            io_bit_reg <= '0;
            io_set_reg <= 1'b0;
            local_rdata_reg <= bsf_pkg::DATA_ZERO;
            rd_io_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            ready_reg <= ready_next;
            done_reg <= done_next;
            wb_valid_reg <= wb_valid_next;
            wb_data_reg <= wb_data_next;
            pc_reg <= pc_next;
            flags_reg <= flags_next;
            io_addr_reg <= io_addr_next;
            io_bit_reg <= io_bit_next;
            io_set_reg <= io_set_next;
            local_rdata_reg <= local_rdata_next;
            rd_io_reg <= rd_io_next;
        end
    end

    // Outputs; bus data picks between two registers, no logic ahead of them
    assign issue_ready = ready_reg;
    assign done = done_reg;
    assign wb.valid = wb_valid_reg;
    assign wb.data = wb_data_reg;
    assign pc = pc_reg;
    assign status_flags = flags_reg;
    assign bus_rdata = rd_io_reg ? mem_rdb : local_rdata_reg;

endmodule : bsf_exec

// ===== bsf_exec_checker.sv
// Assertion checker for the branch, shift and flag execution block
`timescale 1ns/100ps
module bsf_exec_checker (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // Instruction side
    input wire logic in_valid,
    input wire bsf_pkg::bsf_instr_s in_instr,
    input wire logic issue_ready,
    input wire logic done,
    input wire bsf_pkg::bsf_wb_s wb,
    input wire logic [bsf_pkg::PC_W-1:0] pc,
    input wire logic [bsf_pkg::DATA_W-1:0] status_flags,
    // Register bus
    input wire logic bus_wr
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    // Accepted instruction; a status write in the same cycle is left out
    logic take;
    logic is_br;
    logic go;
    logic sel_bit;
    logic [7:0] f;
    logic [7:0] opd;
    logic [11:0] go_vec;
    logic [15:0] k_ext;
    bsf_pkg::bsf_op_e op;
    assign op = in_instr.op;
    assign f = status_flags;
    assign opd = in_instr.operand;
    assign sel_bit = opd[in_instr.bit_sel];
    assign take = in_valid && issue_ready && !bus_wr;
    assign k_ext = {{9{in_instr.offset[6]}}, in_instr.offset};
    // Branch conditions, bit 0 for the minus branch up to the irq-off branch
    assign go_vec = {~f[7], f[7], ~f[3], f[3], ~f[6], f[6], ~f[5], f[5],
        f[2] ^ f[3], ~(f[2] ^ f[3]), ~f[2], f[2]};
    assign is_br = op >= bsf_pkg::OP_BRANCH_ON_NEGATIVE && op <= bsf_pkg::OP_BRANCH_IRQ_OFF;
    assign go = is_br && go_vec[4'(op - 5'd1)];

    property p_br_taken;
        take && go |=> (!issue_ready && !done && pc == $past(pc) + $past(k_ext) + 16'h0001)
            ##1 (done && issue_ready);
    endproperty
    a_br_taken: assert property (p_br_taken) else $error("taken branch wrong");
    property p_br_skip;
        take && is_br && !go |=> done && pc == $past(pc) + 16'h0001 && f == $past(f);
    endproperty
    a_br_skip: assert property (p_br_skip) else $error("untaken branch wrong");
    property p_io_op;
        take && op inside {bsf_pkg::OP_IO_BIT_SET, bsf_pkg::OP_IO_BIT_CLEAR}
            |=> (!issue_ready && !done && f == $past(f)) ##1 (done && pc == $past(pc, 2) + 16'h0001);
    endproperty
    a_io_op: assert property (p_io_op) else $error("io bit op timing wrong");
    property p_lsl;
        take && op == bsf_pkg::OP_LOGICAL_LEFT_SHIFT |=> wb.valid && done
            && wb.data == ($past(opd) << 1) && f == {$past(f[7:4]), wb.data[7] ^ $past(opd[7]),
            wb.data[7], wb.data == 8'h00, $past(opd[7])};
    endproperty
    a_lsl: assert property (p_lsl) else $error("left shift wrong");
    property p_ror;
        take && op == bsf_pkg::OP_ROTATE_RIGHT_CARRY |=> wb.valid
            && wb.data == ({$past(f[0]), 7'h00} | ($past(opd) >> 1)) && f[0] == $past(opd[0]);
    endproperty
    a_ror: assert property (p_ror) else $error("right rotate wrong");
    property p_bst;
        take && op == bsf_pkg::OP_BIT_TO_XFER_FLAG
            |=> f[6] == $past(sel_bit) && (f & 8'hbf) == ($past(f) & 8'hbf);
    endproperty
    a_bst: assert property (p_bst) else $error("bit store wrong");
    property p_bld;
        take && op == bsf_pkg::OP_XFER_FLAG_TO_BIT
            |=> wb.valid && wb.data[$past(in_instr.bit_sel)] == $past(f[6]) && f == $past(f);
    endproperty
    a_bld: assert property (p_bld) else $error("bit load wrong");
    property p_half;
        take && op inside {bsf_pkg::OP_HALF_CARRY_SET, bsf_pkg::OP_HALF_CARRY_CLEAR}
            |=> f == ($past(op) == bsf_pkg::OP_HALF_CARRY_SET ? $past(f) | 8'h20 : $past(f) & 8'hdf);
    endproperty
    a_half: assert property (p_half) else $error("half carry set or clear wrong");
    property p_ovf;
        take && op inside {bsf_pkg::OP_OVERFLOW_FLAG_SET, bsf_pkg::OP_OVERFLOW_FLAG_CLEAR}
            |=> f == ($past(op) == bsf_pkg::OP_OVERFLOW_FLAG_SET ? $past(f) | 8'h08 : $past(f) & 8'hf7);
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow set or clear wrong");
    property p_sgn;
        take && op inside {bsf_pkg::OP_SIGNED_TEST_SET, bsf_pkg::OP_SIGNED_TEST_CLEAR}
            |=> f == ($past(op) == bsf_pkg::OP_SIGNED_TEST_SET ? $past(f) | 8'h10 : $past(f) & 8'hef);
    endproperty
    a_sgn: assert property (p_sgn) else $error("signed test set or clear wrong");
endmodule : bsf_exec_checker

bind bsf_exec bsf_exec_checker u_chk (
    .ref_clk(ref_clk), .srst(srst), .in_valid(in_valid), .in_instr(in_instr),
    .issue_ready(issue_ready), .done(done), .wb(wb), .pc(pc),
    .status_flags(status_flags), .bus_wr(bus_wr)
);

// ===== bsf_io_mem.sv
// I/O register space: one write port, two registered read ports
`timescale 1ns/100ps
module bsf_io_mem (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // Write port
    input wire logic wr_en,
    input wire logic [bsf_pkg::IO_ADDR_W-1:0] wr_addr,
    input wire logic [bsf_pkg::DATA_W-1:0] wr_data,
    // Read port for the execution unit
    input wire logic [bsf_pkg::IO_ADDR_W-1:0] rda_addr,
    output logic [bsf_pkg::DATA_W-1:0] rda_data,
    // Read port for the register bus
    input wire logic [bsf_pkg::IO_ADDR_W-1:0] rdb_addr,
    output logic [bsf_pkg::DATA_W-1:0] rdb_data
);

    logic [bsf_pkg::DATA_W-1:0] mem_reg [bsf_pkg::IO_DEPTH];

    // Storage; cleared on reset so reads are never undefined
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            for (int i = 0; i < bsf_pkg::IO_DEPTH; i++) begin
                mem_reg[i] <= bsf_pkg::DATA_ZERO;
            end
        end else if (wr_en) begin
            mem_reg[wr_addr] <= wr_data;
        end
    end

    // Read data registered; old contents on a same-address write
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            rda_data <= bsf_pkg::DATA_ZERO;
            rdb_data <= bsf_pkg::DATA_ZERO;
        end else begin
            rda_data <= mem_reg[rda_addr];
            rdb_data <= mem_reg[rdb_addr];
        end
    end

endmodule : bsf_io_mem

// ===== bsf_pkg.sv
// Shared constants and types for the branch, shift and flag execution block
package bsf_pkg;

    localparam int DATA_W = 8;
    localparam int PC_W = 16;
    localparam int K_W = 7;
    localparam int BIT_SEL_W = 3;
    localparam int IO_ADDR_W = 5;
    localparam int IO_DEPTH = 32;
    localparam int BUS_ADDR_W = 6;

    // Status flag bit positions
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam int FLAG_T = 6;
    localparam int FLAG_I = 7;

    // Register bus map: I/O space at the bottom, then core state
    localparam logic [BUS_ADDR_W-1:0] ADDR_IO_BASE = 6'h00;
    localparam logic [BUS_ADDR_W-1:0] ADDR_STATUS = 6'h20;
    localparam logic [BUS_ADDR_W-1:0] ADDR_PC_LO = 6'h21;
    localparam logic [BUS_ADDR_W-1:0] ADDR_PC_HI = 6'h22;

    // Reset values and the pc step
    localparam logic [DATA_W-1:0] STATUS_RST = 8'h00;
    localparam logic [PC_W-1:0] PC_RST = 16'h0000;
    localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
    localparam logic [PC_W-1:0] PC_STEP = 16'h0001;

    typedef enum logic [4:0] {
        OP_NOP,
        OP_BRANCH_ON_NEGATIVE, OP_BRANCH_ON_POSITIVE,
        OP_BRANCH_SIGNED_GE, OP_BRANCH_SIGNED_LT,
        OP_BRANCH_HALF_CARRY_ONE, OP_BRANCH_HALF_CARRY_ZERO,
        OP_BRANCH_XFER_FLAG_ONE, OP_BRANCH_XFER_FLAG_ZERO,
        OP_BRANCH_OVERFLOW_ONE, OP_BRANCH_OVERFLOW_ZERO,
        OP_BRANCH_IRQ_ON, OP_BRANCH_IRQ_OFF,
        OP_IO_BIT_SET, OP_IO_BIT_CLEAR,
        OP_LOGICAL_LEFT_SHIFT, OP_LOGICAL_RIGHT_SHIFT,
        OP_ROTATE_LEFT_CARRY, OP_ROTATE_RIGHT_CARRY,
        OP_BIT_TO_XFER_FLAG, OP_XFER_FLAG_TO_BIT,
        OP_HALF_CARRY_SET, OP_HALF_CARRY_CLEAR,
        OP_OVERFLOW_FLAG_SET, OP_OVERFLOW_FLAG_CLEAR,
        OP_SIGNED_TEST_SET, OP_SIGNED_TEST_CLEAR
    } bsf_op_e;

    // One issued instruction with its decoded operands
    typedef struct packed {
        bsf_op_e op;
        logic [K_W-1:0] offset;
        logic [BIT_SEL_W-1:0] bit_sel;
        logic [IO_ADDR_W-1:0] io_addr;
        logic [DATA_W-1:0] operand;
    } bsf_instr_s;

    // Result handed back to the working register file
    typedef struct packed {
        logic valid;
        logic [DATA_W-1:0] data;
    } bsf_wb_s;

endpackage : bsf_pkg

// ===== bsf_shift_unit.sv
// Shift, rotate and bit-load datapath with its flag results
`timescale 1ns/100ps
module bsf_shift_unit (
    // Operation and operands
    input wire bsf_pkg::bsf_op_e op,
    input wire logic [bsf_pkg::DATA_W-1:0] operand,
    input wire logic [bsf_pkg::BIT_SEL_W-1:0] bit_sel,
    input wire logic carry_in,
    input wire logic xfer_in,
    // Results
    output logic [bsf_pkg::DATA_W-1:0] result,
    output logic carry_out,
    output logic zero_out,
    output logic neg_out,
    output logic ovf_out
);

    localparam int MSB = bsf_pkg::DATA_W - 1;

    // Result and carry per operation
    always_comb begin
        result = operand;
        carry_out = carry_in;
        unique case (op)
            bsf_pkg::OP_LOGICAL_LEFT_SHIFT: begin
                result = {operand[MSB-1:0], 1'b0};
                carry_out = operand[MSB];
            end
            bsf_pkg::OP_LOGICAL_RIGHT_SHIFT: begin
                result = {1'b0, operand[MSB:1]};
                carry_out = operand[0];
            end
            bsf_pkg::OP_ROTATE_LEFT_CARRY: begin
                result = {operand[MSB-1:0], carry_in};
                carry_out = operand[MSB];
            end
            bsf_pkg::OP_ROTATE_RIGHT_CARRY: begin
                result = {carry_in, operand[MSB:1]};
                carry_out = operand[0];
            end
            bsf_pkg::OP_XFER_FLAG_TO_BIT: begin
                result[bit_sel] = xfer_in;
            end
            default: begin
                result = operand;
            end
        endcase
    end

    // Flags; overflow follows the usual N xor C of a shift
    always_comb begin
        zero_out = (result == bsf_pkg::DATA_ZERO);
        neg_out = result[MSB];
        ovf_out = result[MSB] ^ carry_out;
    end

endmodule : bsf_shift_unit

// ===== tb_bsf_exec.sv
// Self-checking bench for the branch, shift and flag execution block
`timescale 1ns/100ps
module tb_bsf_exec;
    // Stimulus and observed signals
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic in_valid = 1'b0;
    bsf_pkg::bsf_instr_s in_instr = '0;
    logic issue_ready;
    logic done;
    bsf_pkg::bsf_wb_s wb;
    logic [15:0] pc;
    logic [15:0] exp_pc;
    logic [7:0] status_flags;
    logic [7:0] bus_rdata;
    logic [7:0] rd;
    logic [5:0] bus_addr = 6'h00;
    logic [7:0] bus_wdata = 8'h00;
    logic bus_wr = 1'b0;
    logic bus_rd = 1'b0;
    logic [63:0] r;
    logic [63:0] rows [27];
    int miscompares = 0;
    int compares = 0;
    int n;

    bsf_exec u_dut (
        .ref_clk(ref_clk), .srst(srst), .in_valid(in_valid), .in_instr(in_instr),
        .issue_ready(issue_ready), .done(done), .wb(wb), .pc(pc),
        .status_flags(status_flags), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata)
    );

    // Clock at 100 MHz
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end

    // Hang guard, far beyond the fewer than 200 cycles the run needs
    initial begin
        #100000;
        miscompares++;
        print_verdict();
    end

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic bus_write(input logic [5:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        bus_wr <= 1'b1;
        bus_addr <= a;
        bus_wdata <= d;
        @(posedge ref_clk);
        bus_wr <= 1'b0;
    endtask : bus_write

    // Read data stand from the cycle after the strobe on
    task automatic bus_read(input logic [5:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        bus_rd <= 1'b1;
        bus_addr <= a;
        @(posedge ref_clk);
        bus_rd <= 1'b0;
        #1;
        d = bus_rdata;
    endtask : bus_read

    // Issue one instruction and count cycles up to its completion pulse
    task automatic issue(input bsf_pkg::bsf_op_e op, input logic [7:0] opd,
                         input logic [2:0] bs, input logic [6:0] k, input logic [4:0] io);
        @(posedge ref_clk);
        in_valid <= 1'b1;
        in_instr <= '{op, k, bs, io, opd};
        @(posedge ref_clk);
        in_valid <= 1'b0;
        n = 1;
        #1;
        while (done !== 1'b1 && n < 4) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
    endtask : issue

    task automatic print_verdict();
        if (miscompares == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : print_verdict

    // Rows by opcode: status in, operand, status out, result, bit, offset, cycles, pc step
    initial begin
        rows = '{64'h00_00_00_00_0_00_1_0001, 64'h04_00_04_00_0_05_2_0006,
            64'h04_00_04_00_0_05_1_0001, 64'h0c_00_0c_00_0_7e_2_ffff,
            64'h08_00_08_00_0_3f_2_0040, 64'h20_00_20_00_0_40_2_ffc1,
            64'h20_00_20_00_0_40_1_0001, 64'h00_00_00_00_0_03_1_0001,
            64'h00_00_00_00_0_00_2_0001, 64'hf7_00_f7_00_0_01_1_0001,
            64'hf7_00_f7_00_0_01_2_0002, 64'h80_00_80_00_0_7f_2_0000,
            64'h80_00_80_00_0_7f_1_0001, 64'h5a_00_5a_00_7_00_2_0001,
            64'h5a_00_5a_00_3_00_2_0001, 64'h30_81_39_02_0_00_1_0001,
            64'h00_01_0b_00_0_00_1_0001, 64'h01_80_09_01_0_00_1_0001,
            64'h01_02_0c_81_0_00_1_0001, 64'h00_20_40_00_5_00_1_0001,
            64'h40_00_40_80_7_00_1_0001, 64'h00_00_20_00_0_00_1_0001,
            64'hff_00_df_00_0_00_1_0001, 64'h00_00_08_00_0_00_1_0001,
            64'hff_00_f7_00_0_00_1_0001, 64'h00_00_10_00_0_00_1_0001,
            64'hff_00_ef_00_0_00_1_0001};
        exp_pc = 16'h0000;
        repeat (5) @(posedge ref_clk);
        srst <= 1'b0;
        bus_write(6'h0e, 8'hff);
        for (int i = 0; i < 27; i++) begin
            r = rows[i];
            bus_write(bsf_pkg::ADDR_STATUS, r[63:56]);
            issue(bsf_pkg::bsf_op_e'(5'(i)), r[55:48], r[30:28], r[26:20], 5'(i));
            exp_pc = exp_pc + r[15:0];
            chk("cycles", {12'h000, r[19:16]}, 16'(n));
            chk("pc", exp_pc, pc);
            chk("status", {8'h00, r[47:40]}, {8'h00, status_flags});
            if (i inside {[15:18], 20}) begin
                chk("wb", {8'h01, r[39:32]}, {7'h00, wb.valid, wb.data});
            end
        end
        // Status and I/O bits through the bus, plus an unmapped address
        bus_read(bsf_pkg::ADDR_STATUS, rd);
        chk("status rd", 16'h00ef, {8'h00, rd});
        bus_read(6'h0d, rd);
        chk("io13", 16'h0080, {8'h00, rd});
        bus_read(6'h0e, rd);
        chk("io14", 16'h00f7, {8'h00, rd});
        bus_read(6'h30, rd);
        chk("unmapped", 16'h0000, {8'h00, rd});
        // Back-to-back rotates: the second sees the carry of the first
        bus_write(bsf_pkg::ADDR_STATUS, 8'h00);
        @(posedge ref_clk);
        in_valid <= 1'b1;
        in_instr <= '{bsf_pkg::OP_ROTATE_LEFT_CARRY, 7'h00, 3'h0, 5'h00, 8'h80};
        @(posedge ref_clk);
        in_instr.operand <= 8'h00;
        #1;
        chk("rol1", 16'h0100, {7'h00, wb.valid, wb.data});
        @(posedge ref_clk);
        in_valid <= 1'b0;
        #1;
        chk("rol2", 16'h0101, {7'h00, wb.valid, wb.data});
        exp_pc = exp_pc + 16'h0002;
        // Request offered while a taken branch is busy must be dropped
        bus_write(bsf_pkg::ADDR_STATUS, 8'h00);
        @(posedge ref_clk);
        in_valid <= 1'b1;
        in_instr <= '{bsf_pkg::OP_BRANCH_XFER_FLAG_ZERO, 7'h02, 3'h0, 5'h00, 8'h00};
        @(posedge ref_clk);
        in_instr.op <= bsf_pkg::OP_OVERFLOW_FLAG_SET;
        @(posedge ref_clk);
        in_valid <= 1'b0;
        #1;
        chk("busy done", 16'h0001, {15'h0000, done});
        chk("busy status", 16'h0000, {8'h00, status_flags});
        chk("busy pc", exp_pc + 16'h0003, pc);
        bus_read(bsf_pkg::ADDR_PC_LO, rd);
        chk("pc lo", exp_pc + 16'h0003, {pc[15:8], rd});
        bus_read(bsf_pkg::ADDR_PC_HI, rd);
        chk("pc hi", exp_pc + 16'h0003, {rd, pc[7:0]});
        // Reset in mid-run clears pc and the I/O space and raises ready
        @(posedge ref_clk);
        srst <= 1'b1;
        @(posedge ref_clk);
        srst <= 1'b0;
        #1;
        chk("reset pc", 16'h0000, pc);
        chk("reset ready", 16'h0001, {15'h0000, issue_ready});
        bus_read(6'h0d, rd);
        chk("reset io", 16'h0000, {8'h00, rd});
        print_verdict();
    end
endmodule : tb_bsf_exec
